// *** hdl/iorb_io_space.sv ***
// I/O register space decode, own flag register and scratch registers
`timescale 1ns/1ns
`default_nettype none

`include "iorb_cfg.svh"

module iorb_io_space
  import iorb_pkg::*;
#(
  parameter int unsigned SCR_DEPTH = `IORB_SCR_DEPTH
)
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       req_valid,
  input  wire iorb_op_t   req_op,
  input  wire logic [7:0] req_addr,
  input  wire logic [2:0] req_bit,
  input  wire logic [7:0] req_wdata,
  input  wire logic [7:0] hw_flag_set,
  input  wire logic [7:0] per_rdata,
  output logic            rsp_valid,
  output logic            rsp_err,
  output logic            rsp_skip,
  output logic      [7:0] rsp_rdata,
  output logic            per_sel,
  output logic            per_rd,
  output logic            per_wr,
  output logic      [7:0] per_addr,
  output logic      [7:0] per_wdata,
  output logic      [7:0] per_wmask,
  output logic      [7:0] flags
);

  localparam int unsigned IW = $clog2(SCR_DEPTH);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial begin
    if (SCR_DEPTH != `IORB_SCR_DEPTH) $error("iorb_io_space: scratch depth must be four");
    if (`IORB_SCR2_IO > `IORB_BIT_TOP || `IORB_FLAG_IO > `IORB_BIT_TOP) begin
      $error("iorb_io_space: own registers must be bit addressable");
    end
    if (`IORB_PORT_SLOTS != 64) $error("iorb_io_space: port window must be 64");
  end

  iorb_mem_if #(.DEPTH(SCR_DEPTH)) mem ();

  iorb_scratch_mem #(.DEPTH(SCR_DEPTH)) u_mem (
    .clock (clock),
    .srst  (srst),
    .bus   (mem.mem)
  );

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic            taken;
  logic            dec_err;
  logic            dec_rd;
  logic            dec_wr;
  logic      [7:0] dec_daddr;
  logic      [7:0] dec_mask;
  logic      [7:0] dec_wval;
  iorb_tgt_t       dec_tgt;
  logic   [IW-1:0] dec_idx;

  assign taken = req_valid && ce;

  always_comb begin
    dec_err   = 1'b0;
    dec_daddr = req_addr;
    dec_mask  = 8'hFF;
    dec_wval  = req_wdata;
    dec_rd    = 1'b1;
    dec_wr    = 1'b0;
    case (req_op)
      IORB_OP_PORT_IN, IORB_OP_PORT_OUT: begin
        dec_err   = req_addr > `IORB_PORT_TOP;
        dec_daddr = 8'(req_addr + `IORB_IO_OFS);
        dec_rd    = req_op == IORB_OP_PORT_IN;
        dec_wr    = req_op == IORB_OP_PORT_OUT;
      end
      IORB_OP_BIT_SET, IORB_OP_BIT_CLR: begin
        dec_err   = req_addr > `IORB_BIT_TOP;
        dec_daddr = 8'(req_addr + `IORB_IO_OFS);
        dec_mask  = 8'h01 << req_bit;
        dec_wval  = (req_op == IORB_OP_BIT_SET) ? 8'hFF : 8'h00;
        dec_wr    = 1'b1;
      end
      IORB_OP_SKIP_SET, IORB_OP_SKIP_CLR: begin
        dec_err   = req_addr > `IORB_BIT_TOP;
        dec_daddr = 8'(req_addr + `IORB_IO_OFS);
      end
      IORB_OP_LOAD, IORB_OP_STORE: begin
        dec_err = req_addr < `IORB_IO_OFS;
        dec_rd  = req_op == IORB_OP_LOAD;
        dec_wr  = req_op == IORB_OP_STORE;
      end
      default: begin
        dec_err = 1'b1;
      end
    endcase
  end

  always_comb begin
    dec_tgt = IORB_TGT_PERIPH;
    dec_idx = '0;
    case (dec_daddr)
      `IORB_SCR0_IO + `IORB_IO_OFS: begin
        dec_tgt = IORB_TGT_SCR;
        dec_idx = IW'(0);
      end
      `IORB_SCR1_IO + `IORB_IO_OFS: begin
        dec_tgt = IORB_TGT_SCR;
        dec_idx = IW'(1);
      end
      `IORB_SCR2_IO + `IORB_IO_OFS: begin
        dec_tgt = IORB_TGT_SCR;
        dec_idx = IW'(2);
      end
      `IORB_FLAG_IO + `IORB_IO_OFS: begin
        dec_tgt = IORB_TGT_FLAG;
      end
      default: begin
        dec_tgt = IORB_TGT_PERIPH;
      end
    endcase
  end

  // ****************************************************************
  // Scratch read at request, read-modify-write one cycle later
  // ****************************************************************
  logic            acc_valid;
  logic            acc_err;
  logic            acc_rd;
  logic            acc_wr;
  iorb_op_t        acc_op;
  iorb_tgt_t       acc_tgt;
  logic   [IW-1:0] acc_idx;
  logic      [2:0] acc_bit;
  logic      [7:0] acc_mask;
  logic      [7:0] acc_wval;
  logic      [7:0] cur;
  logic      [7:0] flag_clr;

  always_comb begin
    case (acc_tgt)
      IORB_TGT_SCR:  cur = mem.rd_data;
      IORB_TGT_FLAG: cur = flags;
      default:       cur = per_rdata;
    endcase
  end

  assign mem.ce      = ce;
  assign mem.rd_en   = taken && !dec_err && dec_tgt == IORB_TGT_SCR;
  assign mem.rd_idx  = dec_idx;
  assign mem.wr_en   = ce && acc_valid && !acc_err && acc_wr && acc_tgt == IORB_TGT_SCR;
  assign mem.wr_idx  = acc_idx;
  assign mem.wr_data = (cur & ~acc_mask) | (acc_wval & acc_mask);
  assign flag_clr    = (acc_valid && !acc_err && acc_wr && acc_tgt == IORB_TGT_FLAG) ? acc_wval & acc_mask : 8'h00;

  // ****************************************************************
  // Next state of pipeline, flags and peripheral strobes
  // ****************************************************************
  logic            next_acc_valid;
  logic            next_acc_err;
  logic            next_per_sel;
  logic            next_rsp_skip;
  logic      [7:0] next_flags;
  logic      [7:0] next_rsp_rdata;

  always_comb begin
    next_acc_valid = taken;
    next_acc_err   = taken && dec_err;
    next_per_sel   = taken && !dec_err && dec_tgt == IORB_TGT_PERIPH;
    next_flags     = (flags & ~flag_clr) | hw_flag_set;
    next_rsp_rdata = (acc_valid && !acc_err && acc_rd) ? cur : 8'h00;
    next_rsp_skip  = 1'b0;
    if (acc_valid && !acc_err && (acc_op == IORB_OP_SKIP_SET || acc_op == IORB_OP_SKIP_CLR)) begin
      next_rsp_skip = cur[acc_bit] == (acc_op == IORB_OP_SKIP_SET);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_valid <= 1'b0;
      acc_err   <= 1'b0;
      acc_rd    <= 1'b0;
      acc_wr    <= 1'b0;
      acc_op    <= IORB_OP_LOAD;
      acc_tgt   <= IORB_TGT_PERIPH;
      acc_idx   <= '0;
      acc_bit   <= 3'h0;
      acc_mask  <= 8'h00;
      acc_wval  <= 8'h00;
      per_sel   <= 1'b0;
      per_rd    <= 1'b0;
      per_wr    <= 1'b0;
      per_addr  <= 8'h00;
      per_wdata <= 8'h00;
      per_wmask <= 8'h00;
      flags     <= `IORB_FLAG_RST;
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_skip  <= 1'b0;
      rsp_rdata <= 8'h00;
    end else if (ce) begin
      acc_valid <= next_acc_valid;
      acc_err   <= next_acc_err;
      acc_rd    <= dec_rd;
      acc_wr    <= dec_wr;
      acc_op    <= req_op;
      acc_tgt   <= dec_tgt;
      acc_idx   <= dec_idx;
      acc_bit   <= req_bit;
      acc_mask  <= dec_mask;
      acc_wval  <= dec_wval;
      per_sel   <= next_per_sel;
      per_rd    <= next_per_sel && dec_rd;
      per_wr    <= next_per_sel && dec_wr;
      per_addr  <= dec_daddr;
      per_wdata <= dec_wval;
      per_wmask <= dec_mask;
      flags     <= next_flags;
      rsp_valid <= acc_valid;
      rsp_err   <= acc_err;
      rsp_skip  <= next_rsp_skip;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst || !ce);

  bit_range_a: assert property (
    (taken && (req_op == IORB_OP_BIT_SET || req_op == IORB_OP_BIT_CLR) && req_addr > 8'h1F)
      |-> ##1 !per_sel ##1 (rsp_valid && rsp_err))
    else $error("bit op above 0x1F was not refused");

  skip_only_a: assert property (
    (taken && req_op != IORB_OP_SKIP_SET && req_op != IORB_OP_SKIP_CLR) |-> ##2 !rsp_skip)
    else $error("skip reported for a non-skip access");

  port_range_a: assert property (
    (taken && (req_op == IORB_OP_PORT_IN || req_op == IORB_OP_PORT_OUT) && req_addr > 8'h3F)
      |-> ##2 rsp_err)
    else $error("port access above 0x3F was not refused");

  io_offset_a: assert property (
    (taken && req_op == IORB_OP_PORT_OUT && req_addr < 8'h1B)
      |-> ##1 (per_wr && per_addr == $past(req_addr) + 8'h20))
    else $error("port write not placed at address plus 0x20");

  ext_load_a: assert property (
    (taken && req_op == IORB_OP_LOAD && req_addr >= 8'h60)
      |-> ##1 (per_rd && per_addr == $past(req_addr)) ##1 (rsp_rdata == $past(per_rdata)))
    else $error("extended load not passed through");

  port_window_a: assert property (
    (per_sel && $past(taken) && ($past(req_op) == IORB_OP_PORT_IN || $past(req_op) == IORB_OP_PORT_OUT))
      |-> per_addr < 8'h60)
    else $error("port access reached extended space");

  flag_clear_a: assert property (
    (acc_valid && !acc_err && acc_wr && acc_tgt == IORB_TGT_FLAG)
      |=> ((flags & ($past(acc_wval) & $past(acc_mask)) & ~$past(hw_flag_set)) == 8'h00)
          && ((flags & ~($past(acc_wval) & $past(acc_mask)))
              == (($past(flags) | $past(hw_flag_set)) & ~($past(acc_wval) & $past(acc_mask)))))
    else $error("flag write-one-to-clear misbehaved");

  single_bit_a: assert property (
    (mem.wr_en && (acc_op == IORB_OP_BIT_SET || acc_op == IORB_OP_BIT_CLR))
      |-> (((mem.wr_data ^ mem.rd_data) & ~acc_mask) == 8'h00))
    else $error("bit op disturbed other bits");

  bit_mask_a: assert property (
    (per_wr && (acc_op == IORB_OP_BIT_SET || acc_op == IORB_OP_BIT_CLR))
      |-> ($onehot(per_wmask) && per_wmask[acc_bit]))
    else $error("bit op mask is not the single addressed bit");

  scratch_rw_a: assert property (
    (taken && req_op == IORB_OP_STORE && dec_tgt == IORB_TGT_SCR && !dec_err)
      ##1 (taken && req_op == IORB_OP_LOAD && req_addr == $past(req_addr))
      |-> ##2 (rsp_rdata == $past(req_wdata, 3)))
    else $error("scratch read did not return last write");

endmodule : iorb_io_space

`default_nettype wire

// *** inc/iorb_cfg.svh ***
// Address map, reset values and sizes of the I/O register space block
`ifndef IORB_CFG_SVH
`define IORB_CFG_SVH

// ****************************************************************
// Address windows
// ****************************************************************
`define IORB_BIT_TOP    8'h1F
`define IORB_PORT_TOP   8'h3F
`define IORB_IO_OFS     8'h20
`define IORB_EXT_BASE   8'h60
`define IORB_EXT_TOP    8'hFF
`define IORB_PORT_SLOTS 64

// ****************************************************************
// Own registers, I/O addresses
// ****************************************************************
`define IORB_FLAG_IO    8'h1B
`define IORB_SCR0_IO    8'h1C
`define IORB_SCR1_IO    8'h1D
`define IORB_SCR2_IO    8'h1E
`define IORB_SCR_MAPPED 3
`define IORB_SCR_DEPTH  4

// ****************************************************************
// Reset values
// ****************************************************************
`define IORB_SCR_RST    8'h00
`define IORB_FLAG_RST   8'h00

`endif

// *** inc/iorb_pkg.sv ***
// Types shared by the I/O register space block
`default_nettype none

package iorb_pkg;

  // ****************************************************************
  // Core access kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    IORB_OP_PORT_IN,
    IORB_OP_PORT_OUT,
    IORB_OP_BIT_SET,
    IORB_OP_BIT_CLR,
    IORB_OP_SKIP_SET,
    IORB_OP_SKIP_CLR,
    IORB_OP_LOAD,
    IORB_OP_STORE
  } iorb_op_t;

  // ****************************************************************
  // Access targets
  // ****************************************************************
  typedef enum logic [1:0] {
    IORB_TGT_SCR,
    IORB_TGT_FLAG,
    IORB_TGT_PERIPH
  } iorb_tgt_t;

endpackage : iorb_pkg

`default_nettype wire

// *** inc/iorb_mem_if.sv ***
// Link between the access logic and the scratch register store
`timescale 1ns/1ns
`default_nettype none

interface iorb_mem_if #(parameter int unsigned DEPTH = 4);
  logic                     ce;
  logic                     rd_en;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [7:0]               rd_data;
  logic                     wr_en;
  logic [$clog2(DEPTH)-1:0] wr_idx;
  logic [7:0]               wr_data;

  modport ctl (output ce, rd_en, rd_idx, wr_en, wr_idx, wr_data, input rd_data);
  modport mem (input ce, rd_en, rd_idx, wr_en, wr_idx, wr_data, output rd_data);
endinterface : iorb_mem_if

`default_nettype wire

// *** hdl/iorb_scratch_mem.sv ***
// Scratch register store with registered read data
`timescale 1ns/1ns
`default_nettype none

`include "iorb_cfg.svh"

module iorb_scratch_mem
  import iorb_pkg::*;
#(
  parameter int unsigned DEPTH = `IORB_SCR_DEPTH
)
(
  input  wire logic clock,
  input  wire logic srst,
  iorb_mem_if.mem   bus
);

  initial begin
    if (DEPTH < `IORB_SCR_MAPPED || DEPTH > 16) $error("iorb_scratch_mem: DEPTH out of range");
  end

  localparam int unsigned IW = $clog2(DEPTH);

  logic [7:0] entry      [DEPTH];
  logic [7:0] next_entry [DEPTH];
  logic [7:0] next_rd_data;

  // ****************************************************************
  // Per entry write and clear
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      next_entry[i] = entry[i];
      if (bus.wr_en && bus.wr_idx == IW'(i)) begin
        next_entry[i] = bus.wr_data;
      end
    end

    always_ff @(posedge clock) begin
      if (srst) begin
        entry[i] <= `IORB_SCR_RST;
      end else if (bus.ce) begin
        entry[i] <= next_entry[i];
      end
    end
  end

  // ****************************************************************
  // Read port, write data forwarded on a same-edge hit
  // ****************************************************************
  always_comb begin
    next_rd_data = bus.rd_data;
    if (bus.rd_en) begin
      if (bus.wr_en && bus.wr_idx == bus.rd_idx) begin
        next_rd_data = bus.wr_data;
      end else begin
        next_rd_data = entry[bus.rd_idx];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bus.rd_data <= `IORB_SCR_RST;
    end else if (bus.ce) begin
      bus.rd_data <= next_rd_data;
    end
  end

endmodule : iorb_scratch_mem

`default_nettype wire

// *** verif/iorb_periph_model.sv ***
// Peripheral register model on the far side of the peripheral port
`timescale 1ns/1ns
`default_nettype none

module iorb_periph_model (
  input  wire logic       clock,
  input  wire logic       ce,
  input  wire logic       per_sel,
  input  wire logic       per_rd,
  input  wire logic       per_wr,
  input  wire logic [7:0] per_addr,
  input  wire logic [7:0] per_wdata,
  input  wire logic [7:0] per_wmask,
  output logic      [7:0] per_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;

  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
    last = 8'h00;
  end

  // ****************************************************************
  // Read answer, inverted last value while not read
  // ****************************************************************
  always_comb per_rdata = (per_sel && per_rd) ? mem[per_addr] : ~last;

  // ****************************************************************
  // Masked write, extended registers reached by data address
  // ****************************************************************
  always @(posedge clock) begin
    if (ce && per_sel && per_rd) last <= mem[per_addr];
    if (ce && per_sel && per_wr) mem[per_addr] <= (mem[per_addr] & ~per_wmask) | (per_wdata & per_wmask);
  end
endmodule : iorb_periph_model

`default_nettype wire

// *** verif/iorb_io_space_test.sv ***
// Self-checking bench for the I/O register space block
`timescale 1ns/1ns
`default_nettype none

module iorb_io_space_test;
  import iorb_pkg::*;
  typedef struct {logic err; logic skip; logic chk; logic [7:0] rd;} iorb_rexp_t;
  typedef struct {logic rd; logic wr; logic [7:0] addr; logic [7:0] wd; logic [7:0] wm;} iorb_pexp_t;

  logic       clock, srst, ce, req_valid, rsp_valid, rsp_err, rsp_skip, per_sel, per_rd, per_wr;
  iorb_op_t   req_op;
  logic [2:0] req_bit;
  logic [7:0] req_addr, req_wdata, hw_flag_set, per_rdata, rsp_rdata, per_addr, per_wdata, per_wmask, flags;
  logic [7:0] scr [3];
  logic [7:0] pmem [256];
  logic [7:0] mflag;
  logic [7:0] alist [8] = '{8'h00, 8'h1F, 8'h20, 8'h3F, 8'h40, 8'h5F, 8'h60, 8'hFF};
  iorb_rexp_t rq[$];
  iorb_pexp_t pq[$];
  iorb_rexp_t me;
  iorb_pexp_t mp;
  iorb_op_t   rop;
  int         fails, compares;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  iorb_io_space uut (
    .clock(clock), .srst(srst), .ce(ce), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_bit(req_bit), .req_wdata(req_wdata), .hw_flag_set(hw_flag_set), .per_rdata(per_rdata),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_skip(rsp_skip), .rsp_rdata(rsp_rdata),
    .per_sel(per_sel), .per_rd(per_rd), .per_wr(per_wr), .per_addr(per_addr), .per_wdata(per_wdata),
    .per_wmask(per_wmask), .flags(flags)
  );

  iorb_periph_model periph (
    .clock(clock), .ce(ce), .per_sel(per_sel), .per_rd(per_rd), .per_wr(per_wr), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_wmask(per_wmask), .per_rdata(per_rdata)
  );

  // ****************************************************************
  // Compare and closing
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // ****************************************************************
  // Core request with reference model update
  // ****************************************************************
  task automatic issue(input iorb_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
    iorb_rexp_t e;
    iorb_pexp_t p;
    logic [7:0] da, m, wv, old;
    logic       isbit, isport, rdop, wrop;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_bit <= b;
    req_wdata <= w;
    isbit = op inside {IORB_OP_BIT_SET, IORB_OP_BIT_CLR, IORB_OP_SKIP_SET, IORB_OP_SKIP_CLR};
    isport = op inside {IORB_OP_PORT_IN, IORB_OP_PORT_OUT};
    e = '{1'b0, 1'b0, 1'b1, 8'h00};
    e.err = isbit ? (a > 8'h1F) : isport ? (a > 8'h3F) : (a < 8'h20);
    da = (isbit || isport) ? a + 8'h20 : a;
    m = (op inside {IORB_OP_BIT_SET, IORB_OP_BIT_CLR}) ? 8'h01 << b : 8'hFF;
    wv = (op == IORB_OP_BIT_SET) ? 8'hFF : (op == IORB_OP_BIT_CLR) ? 8'h00 : w;
    rdop = !(op inside {IORB_OP_PORT_OUT, IORB_OP_STORE});
    wrop = op inside {IORB_OP_PORT_OUT, IORB_OP_STORE, IORB_OP_BIT_SET, IORB_OP_BIT_CLR};
    if (!e.err) begin
      if (da == 8'h3B) old = mflag;
      else if (da inside {[8'h3C:8'h3E]}) old = scr[da - 8'h3C];
      else old = pmem[da];
      e.rd = rdop ? old : 8'h00;
      e.skip = (op inside {IORB_OP_SKIP_SET, IORB_OP_SKIP_CLR}) && (old[b] == (op == IORB_OP_SKIP_SET));
      if (da == 8'h3B) begin
        if (wrop && op != IORB_OP_BIT_CLR) mflag = mflag & ~((op == IORB_OP_BIT_SET) ? m : w);
      end else if (da inside {[8'h3C:8'h3E]}) begin
        if (wrop) scr[da - 8'h3C] = (old & ~m) | (wv & m);
      end else begin
        p = '{rdop, wrop, da, wv, m};
        pq.push_back(p);
        if (wrop) pmem[da] = (old & ~m) | (wv & m);
      end
    end
    rq.push_back(e);
  endtask : issue

  task automatic drain;
    @(posedge clock);
    req_valid <= 1'b0;
    for (int i = 0; i < 20 && (rq.size() != 0 || pq.size() != 0); i++) @(posedge clock);
    if (rq.size() != 0 || pq.size() != 0) begin
      fails++;
      final_report();
    end
    #1;
  endtask : drain

  // ****************************************************************
  // Response and peripheral strobe monitor
  // ****************************************************************
  always @(negedge clock) begin
    if (ce === 1'b1 && rsp_valid === 1'b1) begin
      if (rq.size() == 0) check(8'hEE, 8'h00);
      else begin
        me = rq.pop_front();
        check({7'h00, rsp_err}, {7'h00, me.err});
        if (me.chk) check({7'h00, rsp_skip}, {7'h00, me.skip});
        if (me.chk) check(rsp_rdata, me.rd);
      end
    end
    if (ce === 1'b1 && per_sel === 1'b1) begin
      if (pq.size() == 0) check(8'hDD, 8'h00);
      else begin
        mp = pq.pop_front();
        check({6'h00, per_rd, per_wr}, {6'h00, mp.rd, mp.wr});
        check(per_addr, mp.addr);
        if (mp.wr) check(per_wdata & per_wmask, mp.wd & mp.wm);
        if (mp.wr) check(per_wmask, mp.wm);
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req_op = IORB_OP_LOAD;
    req_addr = 8'h00;
    req_bit = 3'h0;
    req_wdata = 8'h00;
    hw_flag_set = 8'h00;
    fails = 0;
    compares = 0;
    mflag = 8'h00;
    foreach (scr[i]) scr[i] = 8'h00;
    foreach (pmem[i]) pmem[i] = 8'(i) ^ 8'hA5;
    void'($urandom(65178));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    #1 check(flags, 8'h00);
    for (int i = 0; i < 3; i++) issue(IORB_OP_LOAD, 8'h3C + 8'(i), 3'h0, 8'h00);
    drain();
    $display("Test reset values done");
    for (int o = 0; o < 8; o++)
      foreach (alist[j]) issue(iorb_op_t'(o), alist[j], 3'h2, 8'h00);
    drain();
    $display("Test address windows done");
    issue(IORB_OP_PORT_OUT, 8'h1C, 3'h0, 8'hA5);
    issue(IORB_OP_LOAD, 8'h3C, 3'h0, 8'h00);
    issue(IORB_OP_BIT_SET, 8'h1D, 3'h7, 8'h00);
    issue(IORB_OP_BIT_CLR, 8'h1C, 3'h0, 8'h00);
    issue(IORB_OP_SKIP_SET, 8'h1C, 3'h2, 8'h00);
    issue(IORB_OP_SKIP_CLR, 8'h1D, 3'h0, 8'h00);
    issue(IORB_OP_STORE, 8'h3E, 3'h0, 8'h5A);
    issue(IORB_OP_LOAD, 8'h3E, 3'h0, 8'h00);
    issue(IORB_OP_PORT_IN, 8'h1E, 3'h0, 8'h00);
    drain();
    $display("Test scratch routes done");
    @(posedge clock);
    hw_flag_set <= 8'h0F;
    @(posedge clock);
    hw_flag_set <= 8'h00;
    mflag = 8'h0F;
    repeat (3) @(posedge clock);
    #1 check(flags, 8'h0F);
    issue(IORB_OP_BIT_CLR, 8'h1B, 3'h0, 8'h00);
    issue(IORB_OP_BIT_SET, 8'h1B, 3'h1, 8'h00);
    issue(IORB_OP_STORE, 8'h3B, 3'h0, 8'h0C);
    issue(IORB_OP_LOAD, 8'h3B, 3'h0, 8'h00);
    drain();
    check(flags, 8'h01);
    $display("Test clear flags done");
    @(posedge clock);
    ce <= 1'b0;
    hw_flag_set <= 8'hF0;
    repeat (2) @(posedge clock);
    #1 check(flags, 8'h01);
    @(posedge clock);
    ce <= 1'b1;
    hw_flag_set <= 8'h00;
    issue(IORB_OP_LOAD, 8'h3B, 3'h0, 8'h00);
    drain();
    check(flags, 8'h01);
    $display("Test clock enable done");
    for (int i = 0; i < 300; i++) begin
      rop = iorb_op_t'($urandom_range(0, 7));
      issue(rop, $urandom_range(0, 1) ? 8'h1B + 8'($urandom_range(0, 3)) + ((rop >= IORB_OP_LOAD) ? 8'h20 : 8'h00)
                 : 8'($urandom), 3'($urandom), 8'($urandom));
    end
    drain();
    $display("Test random traffic done");
    final_report();
  end
endmodule : iorb_io_space_test

`default_nettype wire
